// ===== rtl/supply_integrity_pkg.sv
// Package with register layout, option encodings and timing constants for the supply integrity monitor
package supply_integrity_pkg;
  // Register byte address on APB (single register)
  localparam logic [7:0] SICTRL_ADDR = 8'h00;
  // Field positions
  localparam int BIT_WDG_RST = 0;
  localparam int BIT_BOR_RST = 4;
  localparam int BIT_WARN_FLAG = 5;
  localparam int BIT_WARN_IE = 6;
  // Option encodings for brown-out threshold
  typedef enum logic [1:0] {
    THR_LOW = 2'b00,
    THR_MED = 2'b01,
    THR_HIGH = 2'b10
  } threshold_t;
  // Reset delay figures in CPU cycles
  localparam int DELAY_SHORT_CYC = 256;
  localparam int DELAY_LONG_CYC = 4096;
  localparam logic [12:0] DELAY_SHORT = 13'h0100;
  localparam logic [12:0] DELAY_LONG = 13'h1000;
  localparam logic [31:0] BUS_ZERO = 32'h0000_0000;
  localparam logic [7:0] MAP_ADDR_MASK = 8'hFC;
endpackage

// ===== rtl/supply_integrity_monitor.sv
// Supply integrity monitor: brown-out reset hold, early-warning flag and interrupt, reset cause flags
// Operation
// - Brown-out reset drives the external reset pin low.
// - Brown-out threshold selected by option among low, medium, high.
// - Brown-out detector enabled or disabled as a whole by option.
// - Warning flag bit 5 follows comparator; read only.
// - Early warning works only when brown-out detector enabled.
// - Warning threshold follows the selected brown-out threshold.
// - With enable bit 6 set, every flag toggle raises an interrupt.
// - No warning interrupt for a crossing during the reset delay.
// - Enable set before crossing gives two interrupts: enable and crossing.
// - Enable set after crossing gives exactly one interrupt.
// - Wait mode changes nothing; warning interrupt wakes from Wait.
// - Halt freezes the register; warning interrupt does not wake Halt.
// - Pending warning interrupt cleared on entering its service routine.
// - Interrupt reaches CPU only if enabled and global mask clear.
// - Brown-out flag bit 4 set by hardware, cleared by writing zero.
// - Watchdog flag bit 0 set on watchdog reset, cleared by write zero or brown-out.
// - Brown-out flag survives later external or watchdog resets.
// - Register resets with bits 7:5 zero, bit 4 by reset source; here RST_B clears bit 4 as well, and only a later brown-out sets it.
// - Reset delay is 256 or 4096 cycles by option.
//
// Design decisions made here: register access over APB and the register offsets.
`timescale 1ns/1ns
module supply_integrity_monitor #(
  parameter int SHORT_DELAY = supply_integrity_pkg::DELAY_SHORT_CYC,
  parameter int LONG_DELAY = supply_integrity_pkg::DELAY_LONG_CYC
) (
  input wire logic CLK,
  input wire logic RST_B,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic OPT_BOR_EN,
  input wire logic [1:0] OPT_BOR_THRESHOLD,
  input wire logic OPT_LONG_DELAY,
  input wire logic BOR_COMP_IN,
  input wire logic WARN_COMP_IN,
  input wire logic WDG_RESET_REQ,
  input wire logic EXT_RESET_IN,
  input wire logic HALT_MODE,
  input wire logic WAIT_MODE,
  input wire logic GLOBAL_IRQ_MASK,
  input wire logic IRQ_ACK,
  output logic [1:0] BOR_THRESHOLD_SEL,
  output logic RESET_PIN_OUT,
  output logic RESET_PIN_OE,
  output logic WARN_IRQ,
  output logic WAKE_REQ
);
  typedef enum logic [1:0] {
    ST_RUN = 2'b00,
    ST_BOR = 2'b01,
    ST_DELAY = 2'b10
  } rst_state_t;

  rst_state_t state_reg, state_next;
  logic bor_s1_reg, bor_s2_reg, warn_s1_reg, warn_s2_reg;
  logic wdg_s1_reg, wdg_s2_reg, ext_s1_reg, ext_s2_reg;
  logic warn_flag_reg, warn_ie_reg, bor_flag_reg, wdg_flag_reg, pend_reg;
  logic [12:0] delay_cnt_reg;
  logic [12:0] delay_len;
  logic bor_active, warn_live, warn_toggle, in_delay, delay_done;
  logic wr_hit, rd_hit, mapped, ie_rise, set_pend, bor_event, wdg_event;
  logic [7:0] reg_view;

  // Two-stage synchronisers for the asynchronous comparator and pin inputs
  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      bor_s1_reg <= 1'b0;
      bor_s2_reg <= 1'b0;
      warn_s1_reg <= 1'b0;
      warn_s2_reg <= 1'b0;
      wdg_s1_reg <= 1'b0;
      wdg_s2_reg <= 1'b0;
      ext_s1_reg <= 1'b0;
      ext_s2_reg <= 1'b0;
    end
    else
    begin
      bor_s1_reg <= BOR_COMP_IN;
      bor_s2_reg <= bor_s1_reg;
      warn_s1_reg <= WARN_COMP_IN;
      warn_s2_reg <= warn_s1_reg;
      wdg_s1_reg <= WDG_RESET_REQ;
      wdg_s2_reg <= wdg_s1_reg;
      ext_s1_reg <= EXT_RESET_IN;
      ext_s2_reg <= ext_s1_reg;
    end
  end

  // Brown-out only counts when the option enables the detector
  assign bor_active = OPT_BOR_EN & bor_s2_reg;
  assign delay_len = OPT_LONG_DELAY ? LONG_DELAY[12:0] : SHORT_DELAY[12:0];
  assign in_delay = (state_reg != ST_RUN);
  assign delay_done = (delay_cnt_reg == delay_len);

  // Reset sequence: hold while brown-out, then count the delay
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      ST_RUN:
        if (bor_active)
          state_next = ST_BOR;
      ST_BOR:
        if (!bor_active)
          state_next = ST_DELAY;
      ST_DELAY:
        if (bor_active)
          state_next = ST_BOR;
        else if (delay_done)
          state_next = ST_RUN;
      default:
        state_next = ST_RUN;
    endcase
  end

  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      state_reg <= ST_RUN;
      delay_cnt_reg <= 13'h0000;
    end
    else
    begin
      state_reg <= state_next;
      delay_cnt_reg <= (state_reg == ST_DELAY) ? delay_cnt_reg + 13'h0001 : 13'h0000;
    end
  end

  // The flag tracks the comparator even during the reset delay, but a crossing there
  // raises no event; freezing the flag instead would fire a stale toggle once the delay ends
  assign warn_live = OPT_BOR_EN & warn_s2_reg;
  assign warn_toggle = OPT_BOR_EN & (warn_live != warn_flag_reg) & !in_delay & !HALT_MODE;

  // Bus decode: one register, zero wait states, error on unmapped address
  assign mapped = ((PADDR & supply_integrity_pkg::MAP_ADDR_MASK) == supply_integrity_pkg::SICTRL_ADDR);
  assign wr_hit = PSEL & PENABLE & PWRITE & mapped & !HALT_MODE;
  assign rd_hit = PSEL & PENABLE & !PWRITE & mapped;
  assign ie_rise = wr_hit & PWDATA[supply_integrity_pkg::BIT_WARN_IE] & !warn_ie_reg;
  assign set_pend = (warn_toggle & warn_ie_reg) | ie_rise;
  assign bor_event = (state_reg == ST_BOR);
  assign wdg_event = wdg_s2_reg;

  assign reg_view = {1'b0, warn_ie_reg, warn_flag_reg, bor_flag_reg, 3'b000, wdg_flag_reg};

  // Register bits; all reset values 0, the brown-out flag included
  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      warn_flag_reg <= 1'b0;
      warn_ie_reg <= 1'b0;
      bor_flag_reg <= 1'b0;
      wdg_flag_reg <= 1'b0;
      pend_reg <= 1'b0;
    end
    else
    begin
      // Detector off leaves the flag where it was, so no change can appear
      if (!HALT_MODE && OPT_BOR_EN)
        warn_flag_reg <= warn_live;
      if (wr_hit)
        warn_ie_reg <= PWDATA[supply_integrity_pkg::BIT_WARN_IE];
      // Hardware set wins over software clear
      if (bor_event)
        bor_flag_reg <= 1'b1;
      else if (wr_hit && !PWDATA[supply_integrity_pkg::BIT_BOR_RST])
        bor_flag_reg <= 1'b0;
      if (bor_event)
        wdg_flag_reg <= 1'b0;
      else if (wdg_event)
        wdg_flag_reg <= 1'b1;
      else if (wr_hit && !PWDATA[supply_integrity_pkg::BIT_WDG_RST])
        wdg_flag_reg <= 1'b0;
      if (set_pend)
        pend_reg <= 1'b1;
      else if (IRQ_ACK || (wr_hit && !PWDATA[supply_integrity_pkg::BIT_WARN_IE]))
        pend_reg <= 1'b0;
    end
  end

  // Outputs all registered
  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      PRDATA <= supply_integrity_pkg::BUS_ZERO;
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
      BOR_THRESHOLD_SEL <= 2'b00;
      RESET_PIN_OUT <= 1'b0;
      RESET_PIN_OE <= 1'b0;
      WARN_IRQ <= 1'b0;
      WAKE_REQ <= 1'b0;
    end
    else
    begin
      PREADY <= PSEL & !PENABLE;
      PSLVERR <= PSEL & !PENABLE & !((PADDR & supply_integrity_pkg::MAP_ADDR_MASK) ==
                 supply_integrity_pkg::SICTRL_ADDR);
      PRDATA <= (PSEL & !PENABLE & !PWRITE) ? {24'h00_0000, reg_view} : supply_integrity_pkg::BUS_ZERO;
      BOR_THRESHOLD_SEL <= OPT_BOR_THRESHOLD;
      RESET_PIN_OUT <= 1'b0;
      RESET_PIN_OE <= in_delay;
      WARN_IRQ <= (pend_reg | set_pend) & warn_ie_reg & !GLOBAL_IRQ_MASK & !IRQ_ACK;
      WAKE_REQ <= pend_reg & warn_ie_reg & WAIT_MODE & !HALT_MODE;
    end
  end

  // Reset pin is driven from two cycles after a brown-out is seen
  property p_reset_pin;
    @(posedge CLK) disable iff (!RST_B)
    bor_active |-> ##2 RESET_PIN_OE;
  endproperty
  a_reset_pin: assert property (p_reset_pin) else $error("Reset pin not driven during brown-out");

  property p_flag_ro;
    @(posedge CLK) disable iff (!RST_B)
    (wr_hit && !in_delay && !HALT_MODE && warn_live == warn_flag_reg) |=> $stable(warn_flag_reg);
  endproperty
  a_flag_ro: assert property (p_flag_ro) else $error("Warning flag changed by a write");

  property p_no_opt;
    @(posedge CLK) disable iff (!RST_B)
    !OPT_BOR_EN |=> $stable(warn_flag_reg);
  endproperty
  a_no_opt: assert property (p_no_opt) else $error("Warning event with detector disabled");

  property p_toggle_irq;
    @(posedge CLK) disable iff (!RST_B)
    (warn_toggle && warn_ie_reg) |=> pend_reg;
  endproperty
  a_toggle_irq: assert property (p_toggle_irq) else $error("Flag toggle did not set pending");

  property p_delay_quiet;
    @(posedge CLK) disable iff (!RST_B)
    (in_delay && !ie_rise && !pend_reg) |=> !pend_reg;
  endproperty
  a_delay_quiet: assert property (p_delay_quiet) else $error("Warning event during reset delay");

  property p_ack_clear;
    @(posedge CLK) disable iff (!RST_B)
    (IRQ_ACK && !set_pend) |=> !pend_reg;
  endproperty
  a_ack_clear: assert property (p_ack_clear) else $error("Pending not cleared by acknowledge");

  property p_masked;
    @(posedge CLK) disable iff (!RST_B)
    GLOBAL_IRQ_MASK |=> !WARN_IRQ;
  endproperty
  a_masked: assert property (p_masked) else $error("Interrupt passed global mask");

  property p_bor_flag;
    @(posedge CLK) disable iff (!RST_B)
    bor_event |=> bor_flag_reg && !wdg_flag_reg;
  endproperty
  a_bor_flag: assert property (p_bor_flag) else $error("Brown-out flags wrong");

  property p_halt_freeze;
    @(posedge CLK) disable iff (!RST_B)
    HALT_MODE |=> $stable(warn_ie_reg) && $stable(warn_flag_reg) && !WAKE_REQ;
  endproperty
  a_halt_freeze: assert property (p_halt_freeze) else $error("Register changed in Halt");

  // Further checks on flag tracking, interrupt delivery, reset flags and the bus answer
  property p_flag_live;
    @(posedge CLK) disable iff (!RST_B)
    (OPT_BOR_EN && !HALT_MODE) |=> warn_flag_reg == $past(warn_live);
  endproperty
  a_flag_live: assert property (p_flag_live) else $error("Warning flag not following comparator");

  property p_pend_irq;
    @(posedge CLK) disable iff (!RST_B)
    (pend_reg && warn_ie_reg && !GLOBAL_IRQ_MASK && !IRQ_ACK) |=> WARN_IRQ;
  endproperty
  a_pend_irq: assert property (p_pend_irq) else $error("Pending interrupt not delivered");

  property p_enable_irq;
    @(posedge CLK) disable iff (!RST_B)
    ie_rise |=> pend_reg;
  endproperty
  a_enable_irq: assert property (p_enable_irq) else $error("Enable write did not set pending");

  property p_wdg_set;
    @(posedge CLK) disable iff (!RST_B)
    (wdg_event && !bor_event) |=> wdg_flag_reg;
  endproperty
  a_wdg_set: assert property (p_wdg_set) else $error("Watchdog flag not set");

  property p_bor_keep;
    @(posedge CLK) disable iff (!RST_B)
    (bor_flag_reg && !wr_hit) |=> bor_flag_reg;
  endproperty
  a_bor_keep: assert property (p_bor_keep) else $error("Brown-out flag lost without a write");

  property p_wake;
    @(posedge CLK) disable iff (!RST_B)
    (pend_reg && warn_ie_reg && WAIT_MODE && !HALT_MODE) |=> WAKE_REQ;
  endproperty
  a_wake: assert property (p_wake) else $error("No wake request in Wait");

  property p_pin_low;
    @(posedge CLK) disable iff (!RST_B)
    RESET_PIN_OE |-> !RESET_PIN_OUT;
  endproperty
  a_pin_low: assert property (p_pin_low) else $error("Reset pin driven high");

  property p_delay_end;
    @(posedge CLK) disable iff (!RST_B)
    (state_reg == ST_DELAY && !delay_done) |=> state_reg != ST_RUN;
  endproperty
  a_delay_end: assert property (p_delay_end) else $error("Reset delay ended early");

  property p_ready;
    @(posedge CLK) disable iff (!RST_B)
    (PSEL && !PENABLE) |=> PREADY;
  endproperty
  a_ready: assert property (p_ready) else $error("No ready in access phase");

  property p_slverr;
    @(posedge CLK) disable iff (!RST_B)
    (PSEL && !PENABLE && !mapped) |=> PSLVERR;
  endproperty
  a_slverr: assert property (p_slverr) else $error("No error on unmapped address");

  // Scenarios worth seeing at least once
  c_bor: cover property (@(posedge CLK) disable iff (!RST_B) bor_event ##1 !bor_event);
  c_irq: cover property (@(posedge CLK) disable iff (!RST_B) WARN_IRQ ##[1:20] IRQ_ACK);
  c_enable_irq: cover property (@(posedge CLK) disable iff (!RST_B) ie_rise);
  c_delay_done: cover property (@(posedge CLK) disable iff (!RST_B) state_reg == ST_DELAY ##1 state_reg == ST_RUN);
  c_wake: cover property (@(posedge CLK) disable iff (!RST_B) WAKE_REQ);
endmodule

// ===== bench/cpu_model.sv
// CPU core and interrupt controller model that services the supply warning interrupt
`timescale 1ns/1ns
module cpu_model (
  input wire logic CLK,
  input wire logic WARN_IRQ,
  output logic IRQ_ACK,
  output int IRQ_COUNT
);
  int hold_reg = 0;
  int count_reg = 0;
  logic ack_reg = 1'b0;
  // One driver per output
  assign IRQ_ACK = ack_reg;
  assign IRQ_COUNT = count_reg;
  // Enter the service routine one cycle after a request, then ignore the line while it settles
  always @(posedge CLK)
  begin
    ack_reg <= 1'b0;
    if (hold_reg > 0)
      hold_reg <= hold_reg - 1;
    else if (WARN_IRQ === 1'b1)
    begin
      ack_reg <= 1'b1;
      count_reg <= count_reg + 1;
      hold_reg <= 3;
    end
  end
endmodule

// ===== bench/tb.sv
// Self-checking testbench for the supply integrity monitor
`timescale 1ns/1ns
module tb;
  logic clk, rst_b, psel, penable, pwrite, pready, pslverr, ack, irq, wake, oe, pin_out;
  logic bor_en, bor_comp, warn_comp, wdg, halt, wait_m, mask, err, seen;
  logic [7:0] paddr;
  logic [1:0] thr, thr_sel;
  logic [31:0] pwdata, prdata, q;
  int errors, cmp_count, cycles, irqs, base;
  logic [15:0] rows [3] = '{16'h4040, 16'h5140, 16'h0000};
  supply_integrity_monitor #(.SHORT_DELAY(8), .LONG_DELAY(16)) uut (.CLK(clk), .RST_B(rst_b),
    .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .OPT_BOR_EN(bor_en), .OPT_BOR_THRESHOLD(thr),
    .OPT_LONG_DELAY(1'b0), .BOR_COMP_IN(bor_comp), .WARN_COMP_IN(warn_comp), .WDG_RESET_REQ(wdg),
    .EXT_RESET_IN(1'b0), .HALT_MODE(halt), .WAIT_MODE(wait_m), .GLOBAL_IRQ_MASK(mask), .IRQ_ACK(ack),
    .BOR_THRESHOLD_SEL(thr_sel), .RESET_PIN_OUT(pin_out), .RESET_PIN_OE(oe), .WARN_IRQ(irq), .WAKE_REQ(wake));
  cpu_model partner (.CLK(clk), .WARN_IRQ(irq), .IRQ_ACK(ack), .IRQ_COUNT(irqs));
  // Clock at 100 MHz
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Hang guard, well above the roughly 180 cycles the run needs
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 5000)
    begin
      errors++;
      give_verdict();
    end
  end
  task automatic give_verdict();
    if (errors == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e)
    begin
      errors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  // APB transfer: hold the request until pready is sampled high, then release
  task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h00_0000, d};
    @(posedge clk);
    penable <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 40);
    if (n >= 40) errors++;
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  // Main sequence; reserved bits are always written as zero
  initial
  begin
    {psel, penable, pwrite, bor_comp, warn_comp, wdg, halt, wait_m, mask} = '0;
    {paddr, pwdata, thr, errors, cmp_count, cycles} = '0;
    bor_en = 1'b1;
    rst_b = 1'b0;
    tick(8);
    rst_b <= 1'b1;
    apb(0, 8'h00, 8'h00);
    chk("reset value", 32'h0000_0000, q);
    for (int i = 0; i < 3; i++)
    begin
      apb(1, 8'h00, rows[i][15:8]);
      apb(0, 8'h00, 8'h00);
      chk("row read", {24'h00_0000, rows[i][7:0]}, q);
    end
    apb(1, 8'h00, 8'h40);
    warn_comp <= 1'b1;
    tick(6);
    chk("irqs enable and crossing", 3, 32'(irqs));
    apb(0, 8'h00, 8'h00);
    chk("flag high", 32'h0000_0060, q);
    warn_comp <= 1'b0;
    tick(6);
    chk("irqs on fall", 4, 32'(irqs));
    mask <= 1'b1;
    warn_comp <= 1'b1;
    tick(6);
    chk("masked line", 0, 32'(irq));
    mask <= 1'b0;
    tick(6);
    chk("irqs after unmask", 5, 32'(irqs));
    // Sleeping CPU with the mask set: the wake request must still show
    mask <= 1'b1;
    wait_m <= 1'b1;
    warn_comp <= 1'b0;
    seen = 1'b0;
    repeat (8)
    begin
      @(posedge clk);
      seen |= wake;
    end
    chk("wake in wait", 1, 32'(seen));
    wait_m <= 1'b0;
    mask <= 1'b0;
    halt <= 1'b1;
    apb(1, 8'h00, 8'h00);
    halt <= 1'b0;
    apb(0, 8'h00, 8'h00);
    chk("halt write ignored", 32'h0000_0040, q);
    wdg <= 1'b1;
    tick(2);
    wdg <= 1'b0;
    tick(4);
    apb(0, 8'h00, 8'h00);
    chk("watchdog flag", 32'h0000_0041, q);
    bor_comp <= 1'b1;
    tick(6);
    chk("pin enable", 1, 32'(oe));
    chk("pin level", 0, 32'(pin_out));
    // Supply recovers and crosses the warning level inside the reset delay
    base = irqs;
    bor_comp <= 1'b0;
    warn_comp <= 1'b1;
    tick(40);
    chk("pin released", 0, 32'(oe));
    chk("irqs in delay", 32'(base), 32'(irqs));
    apb(0, 8'h00, 8'h00);
    chk("brownout flags", 32'h0000_0010, q & 32'h0000_0011);
    chk("flag after delay", 32'h0000_0070, q & 32'h0000_0070);
    wdg <= 1'b1;
    tick(2);
    wdg <= 1'b0;
    tick(4);
    apb(0, 8'h00, 8'h00);
    chk("flag kept", 32'h0000_0011, q & 32'h0000_0011);
    apb(1, 8'h00, 8'h00);
    apb(0, 8'h00, 8'h00);
    chk("flags cleared", 32'h0000_0000, q & 32'h0000_0011);
    apb(0, 8'h10, 8'h00);
    chk("unmapped", 1, 32'(err));
    for (int t = 0; t < 3; t++)
    begin
      thr <= 2'(t);
      tick(3);
      chk("threshold", t, 32'(thr_sel));
    end
    // Enable after the crossing: one interrupt only
    base = irqs;
    apb(1, 8'h00, 8'h40);
    tick(6);
    chk("late enable irqs", 32'(base + 1), 32'(irqs));
    // Detector off: no toggles or interrupts; reset flags are not trusted now
    bor_en <= 1'b0;
    tick(2);
    warn_comp <= 1'b0;
    tick(8);
    chk("irqs while off", 32'(base + 1), 32'(irqs));
    apb(0, 8'h00, 8'h00);
    chk("flag frozen off", 32'h0000_0060, q & 32'h0000_0060);
    give_verdict();
  end
endmodule
